/* File: design/wdt_top.sv */
// watchdog timer with control register, sleep handling and status flags
//
// Added by the designer: the register offsets and the address-and-strobe port.
`default_nettype none
`include "wdt_consts.svh"
module wdt_top
	import wdt_pkg::*;
(
	input  wire logic               clk_sys_in,
	input  wire logic               sys_rst_in,
	input  wire logic [1:0]         watchdog_mode_cfg_in,
	input  wire wdt_pkg::wdt_sys_t  sys_in,
	input  wire wdt_pkg::wdt_bus_req_t bus_in,
	output logic [7:0]              rdata_out,
	output logic                    sys_reset_req_out,
	output logic                    wake_req_out,
	output logic                    timeout_flag_n_out,
	output logic                    powerdown_flag_n_out,
	output logic                    irq_out
);
	import wdt_pkg::*;

	logic [1:0]  mode_cfg;
	logic [4:0]  period_select;
	logic        sw_enable_bit;
	logic [22:0] count;
	logic        lfo_tick;
	logic        active;
	logic        clear_now;
	logic        hit;
	logic        timeout_awake;
	logic        timeout_sleep;
	logic        sleep_q;
	logic [1:0]  irq_stat;
	logic [1:0]  irq_mask;
	logic [1:0]  next_irq_stat;
	logic        wr_ctl;
	wdt_state_t  state;
	wdt_state_t  next_state;

	// effective exponent of the prescale ratio
	function automatic logic [4:0] ratio_exp(input logic [4:0] ps);
		if (ps > 5'(`WDT_PS_MAX)) begin
			ratio_exp = 5'(`WDT_PS_BASE_EXP);
		end else begin
			ratio_exp = ps + 5'(`WDT_PS_BASE_EXP);
		end
	endfunction

	// last count value before the time-out, i.e. 2^exp - 1
	function automatic logic [22:0] terminal(input logic [4:0] ps);
		logic [23:0] one_hot;
		one_hot = 24'h00_0001 << ratio_exp(ps);
		terminal = 23'(one_hot - 24'h00_0001);
	endfunction

	wdt_lfo_div u_lfo (
		.clk_sys_in (clk_sys_in),
		.sys_rst_in (sys_rst_in),
		.tick_out   (lfo_tick)
	);

	// config word sampled in the reset cycle, never through the bus
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			mode_cfg <= watchdog_mode_cfg_in;
		end
	end

	always_comb begin
		case (mode_cfg)
			`WDT_MODE_ALWAYS_ON:  active = 1'b1;
			`WDT_MODE_AWAKE_ONLY: active = !sys_in.sleep;
			`WDT_MODE_SOFTWARE:   active = sw_enable_bit;
			`WDT_MODE_OFF:        active = 1'b0;
			default:              active = 1'b0;
		endcase
	end

	assign wr_ctl = bus_in.wr && bus_in.addr == `WDT_ADDR_CONTROL;

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			period_select <= 5'(`WDT_PS_RESET);
			sw_enable_bit <= 1'b0;
		end else if (wr_ctl) begin
			period_select <= bus_in.wdata[`WDT_CTL_PS_MSB:`WDT_CTL_PS_LSB];
			sw_enable_bit <= bus_in.wdata[`WDT_CTL_EN_BIT];
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			sleep_q <= 1'b0;
		end else begin
			sleep_q <= sys_in.sleep;
		end
	end

	// sleep exit is the falling edge of the sleep level
	assign clear_now = sys_in.clear_instr || sys_in.sleep_enter
		|| sys_in.wake_irq || sys_in.osc_fail || !active
		|| sys_in.ost_running || (sleep_q && !sys_in.sleep)
		|| state == WDT_ST_FIRE;

	assign hit = lfo_tick && count == terminal(period_select);

	// only the lfo tick advances the count, cpu clock changes do not
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in || clear_now) begin
			count <= 23'h00_0000;
		end else if (lfo_tick) begin
			count <= count + 23'h00_0001;
		end
	end

	always_comb begin
		case (state)
			WDT_ST_IDLE:  next_state = active ? WDT_ST_COUNT : WDT_ST_IDLE;
			WDT_ST_COUNT: begin
				if (!active) begin
					next_state = WDT_ST_IDLE;
				end else if (hit && !clear_now) begin
					next_state = WDT_ST_FIRE;
				end else begin
					next_state = WDT_ST_COUNT;
				end
			end
			WDT_ST_FIRE:  next_state = active ? WDT_ST_COUNT : WDT_ST_IDLE;
			default:      next_state = WDT_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			state <= WDT_ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	assign timeout_awake = state == WDT_ST_COUNT && next_state == WDT_ST_FIRE
		&& !sys_in.sleep;
	assign timeout_sleep = state == WDT_ST_COUNT && next_state == WDT_ST_FIRE
		&& sys_in.sleep;

	// one-cycle pulses registered from the detection cycle
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			sys_reset_req_out <= 1'b0;
			wake_req_out      <= 1'b0;
		end else begin
			sys_reset_req_out <= timeout_awake;
			wake_req_out      <= timeout_sleep;
		end
	end

	// active-low flags: a sleep time-out drives both low, a clear
	// instruction or the block's own reset drives both high again
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			timeout_flag_n_out   <= 1'b1;
			powerdown_flag_n_out <= 1'b1;
		end else if (timeout_sleep) begin
			timeout_flag_n_out   <= 1'b0;
			powerdown_flag_n_out <= 1'b0;
		end else if (sys_in.clear_instr) begin
			timeout_flag_n_out   <= 1'b1;
			powerdown_flag_n_out <= 1'b1;
		end else if (sys_in.sleep_enter) begin
			powerdown_flag_n_out <= 1'b0;
		end
	end

	// write-one-to-clear, a new event in the same cycle wins
	always_comb begin
		next_irq_stat = irq_stat;
		if (bus_in.wr && bus_in.addr == `WDT_ADDR_IRQ_STAT) begin
			next_irq_stat = irq_stat & ~bus_in.wdata[1:0];
		end
		if (timeout_awake) begin
			next_irq_stat[`WDT_IRQ_RESET_BIT] = 1'b1;
		end
		if (timeout_sleep) begin
			next_irq_stat[`WDT_IRQ_WAKE_BIT] = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			irq_stat <= 2'h0;
		end else begin
			irq_stat <= next_irq_stat;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			irq_mask <= 2'h0;
		end else if (bus_in.wr && bus_in.addr == `WDT_ADDR_IRQ_MASK) begin
			irq_mask <= bus_in.wdata[1:0];
		end
	end

	assign irq_out = |(irq_stat & irq_mask);

	// read data valid the cycle after the strobe, zero otherwise
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in || !bus_in.rd) begin
			rdata_out <= 8'h00;
		end else begin
			case (bus_in.addr)
				`WDT_ADDR_CONTROL:
					rdata_out <= {2'b00, period_select, sw_enable_bit};
				`WDT_ADDR_STATUS:
					rdata_out <= {3'b000, active, mode_cfg, state};
				`WDT_ADDR_IRQ_STAT: rdata_out <= {6'h00, irq_stat};
				`WDT_ADDR_IRQ_MASK: rdata_out <= {6'h00, irq_mask};
				`WDT_ADDR_COUNT0:   rdata_out <= count[7:0];
				`WDT_ADDR_COUNT1:   rdata_out <= count[15:8];
				`WDT_ADDR_COUNT2:   rdata_out <= {1'b0, count[22:16]};
				default:            rdata_out <= 8'h00;
			endcase
		end
	end
endmodule
`default_nettype wire

/* File: design/wdt_consts.svh */
// constants for the watchdog timer block
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH
`define WDT_ADDR_CONTROL     4'h0
`define WDT_ADDR_STATUS      4'h1
`define WDT_ADDR_IRQ_STAT    4'h2
`define WDT_ADDR_IRQ_MASK    4'h3
`define WDT_ADDR_COUNT0      4'h4
`define WDT_ADDR_COUNT1      4'h5
`define WDT_ADDR_COUNT2      4'h6
`define WDT_CTL_EN_BIT       0
`define WDT_CTL_PS_LSB       1
`define WDT_CTL_PS_MSB       5
`define WDT_PS_RESET         5'h0B
`define WDT_PS_MAX           5'h12
`define WDT_PS_BASE_EXP      5
`define WDT_MODE_ALWAYS_ON   2'h3
`define WDT_MODE_AWAKE_ONLY  2'h2
`define WDT_MODE_SOFTWARE    2'h1
`define WDT_MODE_OFF         2'h0
`define WDT_IRQ_RESET_BIT    0
`define WDT_IRQ_WAKE_BIT     1
`define WDT_CLK_HZ           100000000
`define WDT_LFO_HZ           31000
`define WDT_LFO_DIV          ((`WDT_CLK_HZ) / (`WDT_LFO_HZ))
`endif

/* File: design/wdt_pkg.sv */
// types shared by the watchdog timer block
`default_nettype none
package wdt_pkg;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} wdt_bus_req_t;
	typedef struct packed {
		logic sleep;
		logic sleep_enter;
		logic wake_irq;
		logic osc_fail;
		logic ost_running;
		logic clear_instr;
	} wdt_sys_t;
	typedef enum logic [1:0] {
		WDT_ST_IDLE  = 2'b00,
		WDT_ST_COUNT = 2'b01,
		WDT_ST_FIRE  = 2'b11
	} wdt_state_t;
endpackage
`default_nettype wire

/* File: design/wdt_lfo_div.sv */
// divider that stands in for the low-frequency oscillator tick
`default_nettype none
`include "wdt_consts.svh"
module wdt_lfo_div (
	input  wire logic clk_sys_in,
	input  wire logic sys_rst_in,
	output logic      tick_out
);
	logic [11:0] cnt;

	// free running; clock switches of the cpu never reach this divider
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in || cnt == 12'(`WDT_LFO_DIV - 1)) begin
			cnt <= 12'h000;
		end else begin
			cnt <= cnt + 12'h001;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			tick_out <= 1'b0;
		end else begin
			tick_out <= (cnt == 12'(`WDT_LFO_DIV - 1));
		end
	end
endmodule
`default_nettype wire

/* File: tb/wdt_chk.sv */
// port-level assertions for the watchdog block
`default_nettype none
module wdt_chk (
	input wire logic                 clk_sys_in,
	input wire logic                 sys_rst_in,
	input wire logic [1:0]           watchdog_mode_cfg_in,
	input wire wdt_pkg::wdt_sys_t     sys_in,
	input wire wdt_pkg::wdt_bus_req_t bus_in,
	input wire logic [7:0]           rdata_out,
	input wire logic                 sys_reset_req_out,
	input wire logic                 wake_req_out,
	input wire logic                 timeout_flag_n_out,
	input wire logic                 powerdown_flag_n_out,
	input wire logic                 irq_out
);
	import wdt_pkg::*;
	// mode seen by the block is the one present during reset
	logic [1:0] mode;
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			mode <= watchdog_mode_cfg_in;
		end
	end
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (sys_rst_in);
	rst_flags_a: assert property ($fell(sys_rst_in) |->
		timeout_flag_n_out && powerdown_flag_n_out && !sys_reset_req_out)
		else $error("outputs not at reset state");
	rst_pulse_a: assert property (sys_reset_req_out |=> !sys_reset_req_out)
		else $error("reset request longer than one cycle");
	wake_pulse_a: assert property (wake_req_out |=> !wake_req_out)
		else $error("wake request longer than one cycle");
	awake_only_a: assert property (sys_reset_req_out |->
		!$past(sys_in.sleep)) else $error("reset request in sleep");
	off_mode_a: assert property (mode == 2'h0 |->
		!sys_reset_req_out && !wake_req_out) else $error("time-out in off mode");
	sleep_off_a: assert property (mode == 2'h2 |-> !wake_req_out)
		else $error("sleep time-out in awake-only mode");
	clr_block_a: assert property (sys_in.clear_instr |=>
		!sys_reset_req_out && !wake_req_out) else $error("time-out after clear");
	wake_flag_a: assert property (wake_req_out |-> ##[0:1]
		!timeout_flag_n_out) else $error("time-out flag not set on wake");
	ctl_read_a: assert property ($past(bus_in.rd) &&
		$past(bus_in.addr) == 4'h0 |-> rdata_out[7:6] == 2'b00)
		else $error("control top bits not zero");
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the watchdog block
`default_nettype none
`include "wdt_consts.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
	$display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import wdt_pkg::*;
	logic         clk_sys_in;
	logic         sys_rst_in;
	logic [1:0]   mode;
	wdt_sys_t     sys;
	wdt_bus_req_t bus;
	logic [7:0]   rdata;
	logic         rst_req;
	logic         wake;
	logic         irq;
	logic         to_n;
	logic         pd_n;
	int           n_fail;
	int           checked;
	wdt_top dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
		.watchdog_mode_cfg_in(mode), .sys_in(sys), .bus_in(bus),
		.rdata_out(rdata), .sys_reset_req_out(rst_req),
		.wake_req_out(wake), .timeout_flag_n_out(to_n),
		.powerdown_flag_n_out(pd_n), .irq_out(irq));
	initial begin
		clk_sys_in = 1'b0;
		forever #5 clk_sys_in = ~clk_sys_in;
	end
	task automatic wrap_up(input bit hang);
		if (hang) n_fail++;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic reset(input logic [1:0] m);
		mode <= m;
		sys_rst_in <= 1'b1;
		repeat (16) @(posedge clk_sys_in);
		sys_rst_in <= 1'b0;
		@(posedge clk_sys_in);
	endtask
	// a gap cycle follows each access so no strobe is driven twice at once
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_sys_in);
		bus <= '0;
		@(posedge clk_sys_in);
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_sys_in);
		bus <= '0;
		#1 d = rdata;
		@(posedge clk_sys_in);
	endtask
	task automatic t_regs();
		logic [7:0] d;
		rd(4'h0, d);
		`CHK(d, 8'h16)
		wr(4'h0, 8'hFF);
		rd(4'h0, d);
		`CHK(d, 8'h3F)
		rd(4'hF, d);
		`CHK(d, 8'h00)
	endtask
	task automatic t_modes();
		logic [7:0] d;
		logic       e;
		for (int m = 0; m < 4; m++) begin
			for (int s = 0; s < 3; s++) begin
				reset(2'(m));
				wr(4'h0, {7'h00, s != 2});
				sys.sleep <= (s == 1);
				@(posedge clk_sys_in);
				e = m == 3 || (m == 2 && s != 1) || (m == 1 && s != 2);
				rd(4'h1, d);
				`CHK(d[4], e)
				`CHK(d[3:2], 2'(m))
				sys.sleep <= 1'b0;
			end
		end
	endtask
	task automatic t_timeout();
		logic [7:0] d;
		int         n;
		reset(2'h3);
		wr(4'h3, 8'h01);
		wr(4'h0, 8'h26);
		repeat (3300) @(posedge clk_sys_in);
		rd(4'h4, d);
		`CHK(d != 8'h00, 1'b1)
		sys.clear_instr <= 1'b1;
		@(posedge clk_sys_in);
		sys.clear_instr <= 1'b0;
		rd(4'h4, d);
		`CHK(d, 8'h00)
		// reserved period code must behave as the 32-tick period
		// sampled on the falling edge, where the registered pulse is settled
		for (n = 0; n < 120000 && rst_req !== 1'b1; n++)
			@(negedge clk_sys_in);
		if (n == 120000) wrap_up(1'b1);
		`CHK(n > 31 * `WDT_LFO_DIV && n < 33 * `WDT_LFO_DIV, 1'b1)
		@(posedge clk_sys_in);
		`CHK(irq, 1'b1)
		`CHK(to_n, 1'b1)
		`CHK(wake, 1'b0)
		wr(4'h2, 8'h01);
		`CHK(irq, 1'b0)
		sys.sleep_enter <= 1'b1;
		@(posedge clk_sys_in);
		sys.sleep_enter <= 1'b0;
		@(posedge clk_sys_in);
		`CHK(pd_n, 1'b0)
		sys.clear_instr <= 1'b1;
		@(posedge clk_sys_in);
		sys.clear_instr <= 1'b0;
		@(posedge clk_sys_in);
		`CHK(pd_n, 1'b1)
	endtask
	initial begin
		n_fail = 0;
		checked = 0;
		sys_rst_in = 1'b1;
		mode = 2'h3;
		sys = '0;
		bus = '0;
		reset(2'h3);
		t_regs();
		t_modes();
		t_timeout();
		wrap_up(1'b0);
	end
endmodule
bind wdt_top wdt_chk chk (.clk_sys_in, .sys_rst_in, .watchdog_mode_cfg_in,
	.sys_in, .bus_in, .rdata_out, .sys_reset_req_out, .wake_req_out,
	.timeout_flag_n_out, .powerdown_flag_n_out, .irq_out);
`default_nettype wire
